// >>> msi_consts.vh
`ifndef MSI_CONSTS_VH
`define MSI_CONSTS_VH

// Register offsets
`define MSI_A0_STAT 8'hC4
`define MSI_A0_DATA 8'hC7
`define MSI_A1_STAT 8'hCC
`define MSI_A1_DATA 8'hCF
`define MSI_SP_RATE 8'hD2
`define MSI_SP_STAT 8'hD3
`define MSI_SP_DATA 8'hD5
`define MSI_IRQ_STAT 8'hD8
`define MSI_IRQ_MASK 8'hD9
`define MSI_CTRL 8'hDA

// Reset values
`define MSI_ASTAT_RST 8'hC0
`define MSI_SPRATE_RST 3'h0

// Async status field positions
`define MSI_B_TRANSMIT_EMPTY_FLAG 7
`define MSI_B_TC 6
`define MSI_B_RECEIVE_FULL_FLAG 5
`define MSI_B_IDLE 4
`define MSI_B_OR 3
`define MSI_B_NF 2
`define MSI_B_FE 1
`define MSI_B_PF 0
`define MSI_RX_MASK 8'h3F
`define MSI_TX_MASK 8'hC0

// Sync status field positions
`define MSI_B_SYNC_TRANSFER_DONE_FLAG 7
`define MSI_B_WRITE_COLLISION_FLAG 6
`define MSI_B_MODE_FAULT_FLAG 4

// Timing counts
`define MSI_OS_DIV 8'h0D
`define MSI_IDLE_TICKS 8'h9F
`define MSI_SP_EDGES 5'h0F

`endif

// >>> msi_flags_rate.v
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "msi_consts.vh"

// Summary of operation
// - The async status register reads at any time, only channel hardware sets it, and writes do nothing.
// - Receive flags clear by a status read followed by a read of the async data register.
// - That data read clears only the receive flags that were set when the status was read.
// - Transmit empty and complete clear by a status read followed by a data register write.
// - A data write not preceded by a status read is not sent.
// - Transmit empty sets when the held byte moves into the shift register.
// - Transmit complete sets while the transmitter is idle and clears by status read then data write.
// - After reset transmit empty and complete read one and all receive flags read zero.
// - The sync rate register reads and writes at any time and resets to divide by two.
// - The 3-bit rate code divides the clock by two to the power of code plus one.
// - The sync status register reads at any time and writes change no flag.
// - The sync transfer done flag sets after the eighth serial clock cycle.
// - The sync done flag clears by a status read with it set then a data read or write.
module msi_flags_rate #(
   parameter [7:0] OS_DIV = `MSI_OS_DIV
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register port
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata_r,
   // Interrupt
   output reg irq_r,
   // Async serial lines
   input wire [1:0] rxd,
   output wire [1:0] txd,
   // Sync serial lines
   output reg sck_r,
   output reg mosi_r,
   input wire miso
);

   localparam [7:0] OS_END = OS_DIV - 8'h01;

   reg [7:0] os_cnt_r;
   reg os_tick_r;
   reg [1:0] ctrl_r;
   reg [4:0] ist_r;
   reg [4:0] mask_r;
   reg [7:0] rd_nxt;
   wire [15:0] ast;
   wire [15:0] adr;
   wire [3:0] aev;

   // Oversample tick, sixteen per bit
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         os_cnt_r <= 8'h00;
         os_tick_r <= 1'b0;
      end else if (os_cnt_r >= OS_END) begin
         os_cnt_r <= 8'h00;
         os_tick_r <= 1'b1;
      end else begin
         os_cnt_r <= os_cnt_r + 8'h01;
         os_tick_r <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ch
         localparam [7:0] SA = (g == 0) ? `MSI_A0_STAT : `MSI_A1_STAT;
         localparam [7:0] DA = (g == 0) ? `MSI_A0_DATA : `MSI_A1_DATA;
         wire srd = rd && (addr == SA);
         wire drd = rd && (addr == DA);
         wire dwr = wr && (addr == DA);
         wire pe = ctrl_r[g];
         reg [7:0] fl_r;
         reg [7:0] snap_r;
         reg arm_r;
         reg [7:0] tdr_r;
         reg tdr_full_r;
         reg [10:0] tsh_r;
         reg [3:0] tbit_r;
         reg [3:0] tos_r;
         reg tbusy_r;
         reg tx_r;
         reg [1:0] rsy_r;
         reg [2:0] smp_r;
         reg rbusy_r;
         reg [3:0] ros_r;
         reg [3:0] rbit_r;
         reg [9:0] rsh_r;
         reg rnz_r;
         reg rxd_r;
         reg [7:0] rdr_r;
         reg [7:0] fdat_r;
         reg fnz_r;
         reg ffe_r;
         reg fpe_r;
         reg [7:0] idl_r;
         reg idl_arm_r;
         reg idl_set_r;
         reg [7:0] set;
         reg [7:0] clr;
         wire acc = dwr && arm_r;
         wire tx_load = !tbusy_r && tdr_full_r;
         wire rxs = rsy_r[1];
         wire maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
         wire noisy = (|smp_r) && !(&smp_r);
         wire [3:0] last = pe ? 4'hA : 4'h9;

         assign txd[g] = tx_r;
         assign ast[g*8 +: 8] = fl_r;
         assign adr[g*8 +: 8] = rdr_r;
         assign aev[g*2] = rxd_r;
         assign aev[g*2+1] = tx_load;

         // Transmit path; write only accepted after a status read
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               tdr_r <= 8'h00;
               tdr_full_r <= 1'b0;
               tsh_r <= 11'h7FF;
               tbit_r <= 4'h0;
               tos_r <= 4'h0;
               tbusy_r <= 1'b0;
               tx_r <= 1'b1;
            end else begin
               if (tx_load) begin
                  tdr_full_r <= 1'b0;
                  tsh_r <= pe ? {1'b1, ^tdr_r, tdr_r, 1'b0} : {2'b11, tdr_r, 1'b0};
                  tbit_r <= last + 4'h1;
                  tos_r <= 4'h0;
                  tbusy_r <= 1'b1;
               end else if (tbusy_r && os_tick_r) begin
                  tos_r <= tos_r + 4'h1;
                  if (tos_r == 4'hF) begin
                     tsh_r <= {1'b1, tsh_r[10:1]};
                     tbit_r <= tbit_r - 4'h1;
                     if (tbit_r == 4'h1)
                        tbusy_r <= 1'b0;
                  end
               end
               if (acc) begin
                  tdr_r <= wdata;
                  tdr_full_r <= 1'b1;
               end
               tx_r <= tbusy_r ? tsh_r[0] : 1'b1;
            end
         end

         // Receive path; majority of three samples mid-bit
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               rsy_r <= 2'b11;
               smp_r <= 3'b111;
               rbusy_r <= 1'b0;
               ros_r <= 4'h0;
               rbit_r <= 4'h0;
               rsh_r <= 10'h000;
               rnz_r <= 1'b0;
               rxd_r <= 1'b0;
               fdat_r <= 8'h00;
               fnz_r <= 1'b0;
               ffe_r <= 1'b0;
               fpe_r <= 1'b0;
            end else begin
               rsy_r <= {rsy_r[0], rxd[g]};
               rxd_r <= 1'b0;
               if (os_tick_r)
                  smp_r <= {smp_r[1:0], rxs};
               if (os_tick_r && !rbusy_r && !rxs) begin
                  rbusy_r <= 1'b1;
                  ros_r <= 4'h0;
                  rbit_r <= 4'h0;
                  rnz_r <= 1'b0;
               end else if (os_tick_r && rbusy_r) begin
                  ros_r <= ros_r + 4'h1;
                  if (ros_r == 4'h9) begin
                     rbit_r <= rbit_r + 4'h1;
                     rnz_r <= rnz_r | noisy;
                     if (rbit_r == 4'h0 && maj) begin
                        // False start bit
                        rbusy_r <= 1'b0;
                     end else if (rbit_r == last) begin
                        rbusy_r <= 1'b0;
                        rxd_r <= 1'b1;
                        fdat_r <= pe ? rsh_r[8:1] : rsh_r[9:2];
                        fnz_r <= rnz_r | noisy;
                        ffe_r <= !maj;
                        fpe_r <= pe && (^rsh_r[9:1]);
                     end else begin
                        rsh_r <= {maj, rsh_r[9:1]};
                     end
                  end
               end
            end
         end

         // Line quiet for ten bit times after a frame
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               idl_r <= 8'h00;
               idl_arm_r <= 1'b0;
               idl_set_r <= 1'b0;
            end else begin
               idl_set_r <= 1'b0;
               if (rxd_r)
                  idl_arm_r <= 1'b1;
               if (rbusy_r || !rxs) begin
                  idl_r <= 8'h00;
               end else if (os_tick_r && idl_arm_r) begin
                  idl_r <= idl_r + 8'h01;
                  if (idl_r == `MSI_IDLE_TICKS) begin
                     idl_set_r <= 1'b1;
                     idl_arm_r <= 1'b0;
                  end
               end
            end
         end

         // Flag set and clear terms
         always @* begin
            set = 8'h00;
            clr = 8'h00;
            set[`MSI_B_TRANSMIT_EMPTY_FLAG] = tx_load;
            set[`MSI_B_TC] = !tbusy_r && !tdr_full_r && !acc;
            set[`MSI_B_IDLE] = idl_set_r;
            if (rxd_r) begin
               if (fl_r[`MSI_B_RECEIVE_FULL_FLAG]) begin
                  set[`MSI_B_OR] = 1'b1;
               end else begin
                  set[`MSI_B_RECEIVE_FULL_FLAG] = 1'b1;
                  set[`MSI_B_NF] = fnz_r;
                  set[`MSI_B_FE] = ffe_r;
                  set[`MSI_B_PF] = fpe_r;
               end
            end
            if (drd)
               clr = snap_r & `MSI_RX_MASK;
            if (acc)
               clr = snap_r & `MSI_TX_MASK;
         end

         // Flags; a set in the clearing cycle survives
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               fl_r <= `MSI_ASTAT_RST;
               snap_r <= 8'h00;
               arm_r <= 1'b0;
               rdr_r <= 8'h00;
            end else begin
               fl_r <= (fl_r & ~clr) | set;
               if (srd) begin
                  snap_r <= fl_r;
                  arm_r <= 1'b1;
               end else if (drd) begin
                  snap_r <= snap_r & `MSI_TX_MASK;
               end else if (dwr) begin
                  snap_r <= snap_r & `MSI_RX_MASK;
                  arm_r <= 1'b0;
               end
               if (rxd_r && !fl_r[`MSI_B_RECEIVE_FULL_FLAG])
                  rdr_r <= fdat_r;
            end
         end
      end
   endgenerate

   // Sync channel, master, clock idles low, sample on rising edge
   reg [2:0] rate_r;
   reg [7:0] sdiv_r;
   reg [7:0] ssh_r;
   reg [4:0] sedg_r;
   reg sbusy_r;
   reg [1:0] mso_r;
   reg sdone_r;
   reg sync_transfer_done_flag_r;
   reg write_collision_flag_r;
   reg sarm_r;
   reg warm_r;
   wire [7:0] hlim = (8'h01 << rate_r) - 8'h01;
   wire sst = rd && (addr == `MSI_SP_STAT);
   wire swr = wr && (addr == `MSI_SP_DATA);
   wire sacc = swr || (rd && (addr == `MSI_SP_DATA));
   wire [7:0] sstat = {sync_transfer_done_flag_r, write_collision_flag_r, 6'h00};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rate_r <= `MSI_SPRATE_RST;
         sdiv_r <= 8'h00;
         ssh_r <= 8'h00;
         sedg_r <= 5'h00;
         sbusy_r <= 1'b0;
         mso_r <= 2'b00;
         sdone_r <= 1'b0;
         sck_r <= 1'b0;
         mosi_r <= 1'b0;
      end else begin
         mso_r <= {mso_r[0], miso};
         sdone_r <= 1'b0;
         if (wr && addr == `MSI_SP_RATE)
            rate_r <= wdata[2:0];
         if (swr && !sbusy_r) begin
            ssh_r <= wdata;
            mosi_r <= wdata[7];
            sbusy_r <= 1'b1;
            sdiv_r <= 8'h00;
            sedg_r <= 5'h00;
         end else if (sbusy_r) begin
            // Half period of 2^code clocks
            if (sdiv_r >= hlim) begin
               sdiv_r <= 8'h00;
               sedg_r <= sedg_r + 5'h01;
               sck_r <= !sck_r;
               if (!sck_r) begin
                  ssh_r <= {ssh_r[6:0], mso_r[1]};
               end else if (sedg_r == `MSI_SP_EDGES) begin
                  sbusy_r <= 1'b0;
                  sdone_r <= 1'b1;
               end else begin
                  mosi_r <= ssh_r[7];
               end
            end else begin
               sdiv_r <= sdiv_r + 8'h01;
            end
         end
      end
   end

   // Sync status; only hardware and access sequences move it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_transfer_done_flag_r <= 1'b0;
         write_collision_flag_r <= 1'b0;
         sarm_r <= 1'b0;
         warm_r <= 1'b0;
      end else begin
         sync_transfer_done_flag_r <= (sync_transfer_done_flag_r & ~(sarm_r & sacc)) | sdone_r;
         write_collision_flag_r <= (write_collision_flag_r & ~(warm_r & sacc)) | (swr & sbusy_r);
         if (sst) begin
            sarm_r <= sync_transfer_done_flag_r;
            warm_r <= write_collision_flag_r;
         end else if (sacc) begin
            sarm_r <= 1'b0;
            warm_r <= 1'b0;
         end
      end
   end

   // Control, interrupt status and mask
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= 2'b00;
         mask_r <= 5'h00;
         ist_r <= 5'h00;
         irq_r <= 1'b0;
      end else begin
         if (wr && addr == `MSI_CTRL)
            ctrl_r <= wdata[1:0];
         if (wr && addr == `MSI_IRQ_MASK)
            mask_r <= wdata[4:0];
         if (wr && addr == `MSI_IRQ_STAT)
            ist_r <= (ist_r & ~wdata[4:0]) | {sdone_r, aev};
         else
            ist_r <= ist_r | {sdone_r, aev};
         irq_r <= |(ist_r & mask_r);
      end
   end

   // Read decode
   always @* begin
      if (addr == `MSI_A0_STAT)
         rd_nxt = ast[7:0];
      else if (addr == `MSI_A0_DATA)
         rd_nxt = adr[7:0];
      else if (addr == `MSI_A1_STAT)
         rd_nxt = ast[15:8];
      else if (addr == `MSI_A1_DATA)
         rd_nxt = adr[15:8];
      else if (addr == `MSI_SP_RATE)
         rd_nxt = {5'h00, rate_r};
      else if (addr == `MSI_SP_STAT)
         rd_nxt = sstat;
      else if (addr == `MSI_SP_DATA)
         rd_nxt = ssh_r;
      else if (addr == `MSI_IRQ_STAT)
         rd_nxt = {3'h0, ist_r};
      else if (addr == `MSI_IRQ_MASK)
         rd_nxt = {3'h0, mask_r};
      else if (addr == `MSI_CTRL)
         rd_nxt = {6'h00, ctrl_r};
      else
         rd_nxt = 8'h00;
   end

   // Read data valid only in the cycle after the strobe
   always @(posedge clk or posedge rst) begin
      if (rst)
         rdata_r <= 8'h00;
      else
         rdata_r <= rd ? rd_nxt : 8'h00;
   end

endmodule
`default_nettype wire

// >>> msi_flags_rate_chk.sv
`timescale 1ns/1ps
`default_nettype none
module msi_flags_rate_chk #(
   parameter [7:0] OS_DIV = 8'h0D
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata_r,
   // Interrupt
   input wire logic irq_r,
   // Serial lines
   input wire logic [1:0] rxd,
   input wire logic [1:0] txd,
   input wire logic sck_r,
   input wire logic mosi_r,
   input wire logic miso
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [2:0] rate_q;
   logic [7:0] mask_q;
   logic [8:0] hcnt;
   logic [3:0] falls;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rate_q <= 3'h0;
         mask_q <= 8'h00;
         hcnt <= 9'h000;
         falls <= 4'h0;
      end else begin
         if (wr && addr == 8'hD2) rate_q <= wdata[2:0];
         if (wr && addr == 8'hD9) mask_q <= wdata;
         hcnt <= sck_r ? hcnt + 9'h001 : 9'h000;
         if (wr && addr == 8'hD5) falls <= 4'h0;
         else if ($fell(sck_r)) falls <= falls + 4'h1;
      end
   end
   a_rdata_quiet: assert property (!$past(rd) |-> rdata_r == 8'h00)
      else $error("read data not zero");
   a_rate_readback: assert property (
      $past(rd) && $past(addr) == 8'hD2 |-> rdata_r == {5'h00, rate_q})
      else $error("rate readback wrong");
   a_half_period: assert property (
      $fell(sck_r) |-> hcnt == (9'h001 << rate_q))
      else $error("serial clock half period wrong");
   a_done_after_eight: assert property (
      $past(rd) && $past(addr) == 8'hD3 && rdata_r[7] |-> falls == 4'h8)
      else $error("done flag before eighth clock");
   a_sync_stat_unused: assert property (
      $past(rd) && $past(addr) == 8'hD3 |-> rdata_r[5:0] == 6'h00)
      else $error("unused sync status bits set");
   a_tc_implies_empty: assert property (
      $past(rd) && ($past(addr) == 8'hC4 || $past(addr) == 8'hCC) && rdata_r[6] |-> rdata_r[7])
      else $error("complete without empty");
   a_irq_masked: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !irq_r)
      else $error("interrupt while fully masked");
   a_sync_stat_write: assert property (
      rd && addr == 8'hD3 ##1 wr && addr == 8'hD3 ##1 rd && addr == 8'hD3
      |=> rdata_r == $past(rdata_r, 2))
      else $error("sync status changed by write");
endmodule

bind msi_flags_rate msi_flags_rate_chk #(.OS_DIV(OS_DIV)) u_chk (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .irq_r(irq_r), .rxd(rxd), .txd(txd),
   .sck_r(sck_r), .mosi_r(mosi_r), .miso(miso));
`default_nettype wire

// >>> msi_peer.sv
`timescale 1ns/1ps
`default_nettype none
module msi_peer #(
   parameter int BIT_CLKS = 32
) (
   // Clock
   input wire logic clk,
   // Frame request
   input wire logic go,
   input wire logic [7:0] dat,
   input wire logic bad_stop,
   // Async line toward the block
   output logic line,
   // Sync lines
   input wire logic sck,
   output logic miso
);
   logic [9:0] frm;
   logic [7:0] sh = 8'hA5;
   logic sck_q = 1'b0;
   int i;
   initial line = 1'b1;
   assign miso = sh[7];
   // Rotates, so every whole transfer returns the same byte
   always @(posedge clk) begin
      sck_q <= sck;
      if (sck_q && !sck) sh <= {sh[6:0], sh[7]};
   end
   always @(posedge clk) begin
      if (go) begin
         frm = {~bad_stop, dat, 1'b0};
         for (i = 0; i < 10; i++) begin
            line <= frm[i];
            repeat (BIT_CLKS) @(posedge clk);
         end
         line <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> msi_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam [7:0] OSD = 8'h02;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic go = 1'b0;
   logic bad_stop = 1'b0;
   logic [7:0] pdat = 8'h00;
   logic [7:0] rq;
   logic iq;
   int num_errors = 0;
   int checked = 0;
   wire [7:0] rdata_r;
   wire [1:0] txd;
   wire irq_r, sck_r, mosi_r, miso, line;
   // Write flag, address, write data or expected read data
   logic [16:0] rows [0:11] = '{
      {1'b0, 8'hC4, 8'hC0}, {1'b0, 8'hCC, 8'hC0}, {1'b0, 8'hD2, 8'h00}, {1'b0, 8'hD3, 8'h00},
      {1'b1, 8'hD2, 8'hFF}, {1'b0, 8'hD2, 8'h07}, {1'b1, 8'hC4, 8'h00}, {1'b0, 8'hC4, 8'hC0},
      {1'b1, 8'hD3, 8'hFF}, {1'b0, 8'hD3, 8'h00}, {1'b1, 8'hD4, 8'h5A}, {1'b0, 8'hD4, 8'h00}};
   msi_flags_rate #(.OS_DIV(OSD)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_r(rdata_r), .irq_r(irq_r), .rxd({txd[0], line}), .txd(txd), .sck_r(sck_r), .mosi_r(mosi_r),
      .miso(miso));
   msi_peer #(.BIT_CLKS(16 * int'(OSD))) peer (.clk(clk), .go(go), .dat(pdat), .bad_stop(bad_stop),
      .line(line), .sck(sck_r), .miso(miso));
   always #12.5 clk = ~clk;
   // Read answers stand only between two edges
   always @(negedge clk) begin
      rq <= rdata_r;
      iq <= irq_r;
   end
   task automatic results();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic acc(input logic r, w, input logic [7:0] a, d);
      rd <= r;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      repeat (n) acc(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic rdc(input logic [7:0] a, e);
      acc(1'b1, 1'b0, a, 8'h00);
      acc(1'b0, 1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), rq, e);
   endtask
   task automatic poll(input logic [7:0] a, input int b);
      int n;
      n = 0;
      do begin
         acc(1'b1, 1'b0, a, 8'h00);
         acc(1'b0, 1'b0, a, 8'h00);
         n++;
      end while (rq[b] !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         num_errors++;
         results();
      end
   endtask
   task automatic send(input logic [7:0] d, input logic bad);
      pdat <= d;
      bad_stop <= bad;
      go <= 1'b1;
      idle(1);
      go <= 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[k]) begin
         if (rows[k][16]) acc(1'b0, 1'b1, rows[k][15:8], rows[k][7:0]);
         else rdc(rows[k][15:8], rows[k][7:0]);
      end
      for (int c = 0; c < 8; c++) begin
         acc(1'b0, 1'b1, 8'hD2, c[7:0]);
         acc(1'b0, 1'b1, 8'hD5, 8'h3C);
         rdc(8'hD3, 8'h00);
         poll(8'hD3, 7);
      end
      rdc(8'hD5, 8'hA5);
      rdc(8'hD3, 8'h00);
      acc(1'b1, 1'b0, 8'hD3, 8'h00);
      acc(1'b0, 1'b1, 8'hD3, 8'hFF);
      rdc(8'hD3, 8'h00);
      // Second write has no status read before it
      rdc(8'hC4, 8'hC0);
      acc(1'b0, 1'b1, 8'hC7, 8'h3C);
      acc(1'b0, 1'b1, 8'hC7, 8'h55);
      idle(4);
      rdc(8'hC4, 8'h80);
      acc(1'b0, 1'b1, 8'hC7, 8'hA6);
      idle(2);
      rdc(8'hC4, 8'h00);
      poll(8'hCC, 5);
      rdc(8'hCF, 8'h3C);
      poll(8'hCC, 5);
      rdc(8'hCF, 8'hA6);
      idle(500);
      rdc(8'hCC, 8'hD0);
      rdc(8'hCF, 8'hA6);
      rdc(8'hCC, 8'hC0);
      rdc(8'hC4, 8'hC0);
      send(8'h81, 1'b0);
      rdc(8'hC4, 8'hC0);
      idle(400);
      rdc(8'hC7, 8'h81);
      rdc(8'hC4, 8'hE0);
      send(8'h7E, 1'b1);
      idle(400);
      // Overrun keeps the held byte and sets no error flags of the lost frame
      rdc(8'hC4, 8'hE8);
      rdc(8'hC7, 8'h81);
      rdc(8'hC4, 8'hC0);
      chk("irq", {7'h00, iq}, 8'h00);
      acc(1'b0, 1'b1, 8'hD9, 8'h01);
      idle(3);
      chk("irq", {7'h00, iq}, 8'h01);
      acc(1'b0, 1'b1, 8'hD8, 8'h01);
      idle(3);
      chk("irq", {7'h00, iq}, 8'h00);
      rdc(8'hD8, 8'h16);
      acc(1'b0, 1'b1, 8'hD2, 8'h03);
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      rdc(8'hD2, 8'h00);
      rdc(8'hC4, 8'hC0);
      results();
   end
endmodule
`default_nettype wire
